// file: logic/abs_defs.svh
`ifndef ABS_DEFS_SVH
`define ABS_DEFS_SVH
// register byte offsets
`define ABS_OFS_CTRL 12'h000
`define ABS_OFS_STATUS 12'h004
`define ABS_OFS_TARGET 12'h008
`define ABS_OFS_SPREAD 12'h00C
`define ABS_OFS_HEAD 12'h010
// ctrl fields
`define ABS_CTRL_ACTIVE 0
`define ABS_CTRL_OPEN_DET 1
`define ABS_CTRL_CFG_LSB 4
// spread fields
`define ABS_SPR_DEV_LSB 0
`define ABS_SPR_RATE_LSB 4
`define ABS_SPR_DEV_RST 2'b10
`define ABS_SPR_RATE_RST 2'b00
// status bits
`define ABS_ST_OVPL 0
`define ABS_ST_OVPH 1
`define ABS_ST_OCP 2
`define ABS_ST_EXT 3
`define ABS_ST_SS 4
`define ABS_ST_RECOV 5
// target code span and initial point (88 percent)
`define ABS_TGT_MAX 10'h3FF
`define ABS_TGT_INIT 10'h384
// thresholds as offsets from present target, in target codes
`define ABS_OVPL_OFS 10'h02C
`define ABS_OVPH_OFS 10'h072
`define ABS_UVP_OFS 10'h043
// headroom threshold and hysteresis, in sample codes
`define ABS_HEAD_RST 8'h20
`define ABS_HYS 8'h08
// timing
`define ABS_CLK_HZ 25000000
`define ABS_UVP_MS 110
`define ABS_UVP_CYC ((`ABS_CLK_HZ / 1000) * `ABS_UVP_MS)
`define ABS_SAMPLE_CYC 16'h0100
// sync detection: a sync edge within this window means clock present
`define ABS_SYNC_MISS_CYC 16'h0200
`endif

// file: logic/abs_pkg.sv
package abs_pkg;
  typedef enum logic [1:0] {
    ABS_ST_INIT = 2'b00,
    ABS_ST_ADAPT = 2'b01,
    ABS_ST_RECOVER = 2'b10
  } abs_state_t;
  typedef struct packed {
    logic ovpl;
    logic ovph;
    logic ocp;
  } abs_faults_t;
  typedef struct packed {
    logic [1:0] dev;
    logic [1:0] rate;
  } abs_spread_t;
endpackage

// file: logic/abs_uvp_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "abs_defs.svh"
module abs_uvp_timer #(
  parameter int unsigned UVP_CYC = `ABS_UVP_CYC
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic under_in,
  output logic expire_out
);
  logic [22:0] cnt_r;
  // runs while under; drops the instant the output recovers
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !under_in) begin
      cnt_r <= 23'h00_0000; // R12
    end else if (cnt_r != 23'(UVP_CYC)) begin
      cnt_r <= cnt_r + 23'h00_0001; // R11
    end
  end
  assign expire_out = under_in && (cnt_r == 23'(UVP_CYC));
endmodule
`default_nettype wire

// file: logic/abs_sync_detect.sv
`timescale 1ns/10ps
`default_nettype none
`include "abs_defs.svh"
module abs_sync_detect (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic sync_in,
  output logic ext_clk_out,
  output logic level_out
);
  logic prev_r;
  logic [15:0] miss_r;
  // a toggling pin means external clock; a quiet pin gives the static level
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      prev_r <= 1'b0;
      miss_r <= `ABS_SYNC_MISS_CYC;
      ext_clk_out <= 1'b0;
      level_out <= 1'b0;
    end else begin
      prev_r <= sync_in;
      if (sync_in != prev_r) begin
        miss_r <= 16'h0000;
        ext_clk_out <= 1'b1; // R18
      end else if (miss_r != `ABS_SYNC_MISS_CYC) begin
        miss_r <= miss_r + 16'h0001;
      end else begin
        ext_clk_out <= 1'b0; // R15
        level_out <= prev_r;
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/abs_top.sv
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "abs_defs.svh"
// What this block does
// R01: only sinks enabled by string config take part in the voltage loop.
// R02: strings with open or short faults are dropped from the loop.
// R03: sample sinks periodically; raise target if any is below headroom.
// R04: step target down until any sink reaches headroom, with hysteresis.
// R05: before sinks are active, hold target at 88 percent of span.
// R06: once sinks are active, switch to automatic adjustment.
// R07: open detection or all strings unused lets target climb to maximum.
// R08: fault thresholds are offsets tracking the present target.
// R09: at overvoltage-low, stop switching, set flag, resume when it falls.
// R10: at overvoltage-high, enter fault recovery and set flag.
// R11: at undervoltage run 110 ms timer; on expiry recover, set overcurrent.
// R12: recovering above undervoltage before expiry clears timer, no fault.
// R13: without external clock, sync high enables spread, low disables it.
// R14: external 100-2222 kHz clock on sync drives boost, spread disabled.
// R15: if sync clock stops, use resistor clock, spread from final level.
// R16: deviation 00=3.3,01=4.3,10=5.3 (reset),11=7.2 percent.
// R17: modulation 00=200 Hz (reset),01=500,10=800,11=1200 Hz.
// R18: detect external sync clock, else fall back to internal clock.
module abs_top
  import abs_pkg::*;
#(
  parameter int unsigned UVP_CYC = `ABS_UVP_CYC
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog side
  input wire logic [47:0] sink_output_pin_in,
  input wire logic [5:0] string_fault_in,
  input wire logic [9:0] boost_level_in,
  input wire logic boost_sync_input_in,
  output logic [9:0] boost_target_out,
  output logic switch_enable_out,
  output logic fault_recovery_out,
  output logic ext_sync_select_out,
  output logic spread_enable_out,
  output logic [1:0] spread_deviation_out,
  output logic [1:0] spread_modulation_rate_out
);
  // string_config_setting: bit per sink, written by software
  logic [5:0] string_config_setting_r;
  logic sinks_active_r;
  logic open_detect_r;
  logic [7:0] headroom_r;
  abs_spread_t spread_r;
  abs_faults_t flags_r;
  abs_state_t state_r;
  logic [9:0] target_r;
  logic [15:0] samp_r;
  logic ext_clk;
  logic sync_level;
  logic uvp_expire;
  logic [5:0] monitored;
  logic any_low;
  logic any_at;
  logic over_low;
  logic over_high;
  logic under;
  logic aw_hold_r;
  logic w_hold_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic [31:0] rd_val;

  function automatic logic [7:0] sink_v(input logic [47:0] v, input int unsigned i);
    sink_v = v[i*8 +: 8];
  endfunction

  // which sinks steer the loop
  assign monitored = string_config_setting_r & ~string_fault_in; // R01 R02

  always_comb begin
    any_low = 1'b0;
    any_at = 1'b0;
    for (int unsigned i = 0; i < 6; i++) begin
      if (monitored[i] && (sink_v(sink_output_pin_in, i) < headroom_r)) begin
        any_low = 1'b1; // R03
      end
      // one bit wider so a high headroom setting cannot wrap the band
      if (monitored[i]
          && ({1'b0, sink_v(sink_output_pin_in, i)} < {1'b0, headroom_r} + {1'b0, `ABS_HYS})) begin
        any_at = 1'b1; // R04
      end
    end
  end

  // thresholds ride on the target, so a retarget moves them too
  assign over_low = {1'b0, boost_level_in} >= {1'b0, target_r} + {1'b0, `ABS_OVPL_OFS}; // R08
  assign over_high = {1'b0, boost_level_in} >= {1'b0, target_r} + {1'b0, `ABS_OVPH_OFS}; // R08
  assign under = {1'b0, boost_level_in} + {1'b0, `ABS_UVP_OFS} <= {1'b0, target_r}; // R08

  abs_uvp_timer #(
    .UVP_CYC(UVP_CYC)
  ) u_uvp (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .under_in(under && state_r == ABS_ST_ADAPT),
    .expire_out(uvp_expire)
  );

  abs_sync_detect u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .sync_in(boost_sync_input_in),
    .ext_clk_out(ext_clk),
    .level_out(sync_level)
  );

  // sample tick
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || samp_r == `ABS_SAMPLE_CYC) begin
      samp_r <= 16'h0000;
    end else begin
      samp_r <= samp_r + 16'h0001;
    end
  end

  // loop state; recovery is left only by reset or sinks going inactive
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_r <= ABS_ST_INIT;
    end else begin
      unique case (state_r)
        ABS_ST_INIT: begin
          if (sinks_active_r) begin
            state_r <= ABS_ST_ADAPT; // R06
          end
        end
        ABS_ST_ADAPT: begin
          if (over_high || uvp_expire) begin
            state_r <= ABS_ST_RECOVER; // R10 R11
          end else if (!sinks_active_r) begin
            state_r <= ABS_ST_INIT;
          end
        end
        ABS_ST_RECOVER: begin
          if (!sinks_active_r) begin
            state_r <= ABS_ST_INIT;
          end
        end
        default: state_r <= ABS_ST_INIT;
      endcase
    end
  end

  // boost target stepping, one code per sample
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      target_r <= `ABS_TGT_INIT;
    end else if (state_r != ABS_ST_ADAPT) begin
      target_r <= `ABS_TGT_INIT; // R05
    end else if (samp_r == `ABS_SAMPLE_CYC) begin
      if (open_detect_r || monitored == 6'h00) begin
        if (target_r != `ABS_TGT_MAX) begin
          target_r <= target_r + 10'h001; // R07
        end
      end else if (any_low) begin
        if (target_r != `ABS_TGT_MAX) begin
          target_r <= target_r + 10'h001; // R03
        end
      end else if (!any_at && target_r != 10'h000) begin
        target_r <= target_r - 10'h001; // R04
      end
    end
  end

  // sticky flags: hardware set wins over software clear
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      flags_r <= '0;
    end else begin
      if (do_write && awaddr_r == `ABS_OFS_STATUS && wstrb_r[0]) begin
        flags_r.ovpl <= flags_r.ovpl & ~wdata_r[`ABS_ST_OVPL];
        flags_r.ovph <= flags_r.ovph & ~wdata_r[`ABS_ST_OVPH];
        flags_r.ocp <= flags_r.ocp & ~wdata_r[`ABS_ST_OCP];
      end
      if (state_r == ABS_ST_ADAPT && over_low) begin
        flags_r.ovpl <= 1'b1; // R09
      end
      if (state_r == ABS_ST_ADAPT && over_high) begin
        flags_r.ovph <= 1'b1; // R10
      end
      if (state_r == ABS_ST_ADAPT && uvp_expire) begin
        flags_r.ocp <= 1'b1; // R11
      end
    end
  end

  assign boost_target_out = target_r;
  // switching stops above overvoltage-low and resumes once it falls
  assign switch_enable_out = (state_r != ABS_ST_RECOVER) && !over_low; // R09
  assign fault_recovery_out = (state_r == ABS_ST_RECOVER);
  assign ext_sync_select_out = ext_clk; // R14 R18
  // an external clock forbids spread; otherwise the static level decides
  assign spread_enable_out = !ext_clk && sync_level; // R13 R14 R15
  assign spread_deviation_out = spread_r.dev; // R16
  assign spread_modulation_rate_out = spread_r.rate; // R17

  // axi write: address and data taken in either order
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r <= `ABS_OFS_HEAD) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sinks_active_r <= 1'b0;
      open_detect_r <= 1'b0;
      string_config_setting_r <= 6'h3F;
      spread_r <= {`ABS_SPR_DEV_RST, `ABS_SPR_RATE_RST};
      headroom_r <= `ABS_HEAD_RST;
    end else if (do_write && wstrb_r[0]) begin
      if (awaddr_r == `ABS_OFS_CTRL) begin
        sinks_active_r <= wdata_r[`ABS_CTRL_ACTIVE];
        open_detect_r <= wdata_r[`ABS_CTRL_OPEN_DET];
        if (wstrb_r[1]) begin
          string_config_setting_r <= wdata_r[`ABS_CTRL_CFG_LSB +: 6];
        end
      end else if (awaddr_r == `ABS_OFS_SPREAD) begin
        spread_r.dev <= wdata_r[`ABS_SPR_DEV_LSB +: 2];
        spread_r.rate <= wdata_r[`ABS_SPR_RATE_LSB +: 2];
      end else if (awaddr_r == `ABS_OFS_HEAD) begin
        headroom_r <= wdata_r[7:0];
      end
    end
  end

  // read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case ({s_axi_araddr[11:2], 2'b00})
      `ABS_OFS_CTRL: begin
        rd_val[`ABS_CTRL_ACTIVE] = sinks_active_r;
        rd_val[`ABS_CTRL_OPEN_DET] = open_detect_r;
        rd_val[`ABS_CTRL_CFG_LSB +: 6] = string_config_setting_r;
      end
      `ABS_OFS_STATUS: begin
        rd_val[`ABS_ST_OVPL] = flags_r.ovpl;
        rd_val[`ABS_ST_OVPH] = flags_r.ovph;
        rd_val[`ABS_ST_OCP] = flags_r.ocp;
        rd_val[`ABS_ST_EXT] = ext_clk;
        rd_val[`ABS_ST_SS] = spread_enable_out;
        rd_val[`ABS_ST_RECOV] = fault_recovery_out;
      end
      `ABS_OFS_TARGET: rd_val[9:0] = target_r;
      `ABS_OFS_SPREAD: begin
        rd_val[`ABS_SPR_DEV_LSB +: 2] = spread_r.dev;
        rd_val[`ABS_SPR_RATE_LSB +: 2] = spread_r.rate;
      end
      `ABS_OFS_HEAD: rd_val[7:0] = headroom_r;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // axi read, one cycle
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= ({s_axi_araddr[11:2], 2'b00} <= `ABS_OFS_HEAD) ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  ovph_recover_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (state_r == ABS_ST_ADAPT && over_high) |=> fault_recovery_out && flags_r.ovph)
    else $error("overvoltage-high did not enter recovery"); // R10
  ovpl_stop_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (state_r == ABS_ST_ADAPT && over_low) |-> !switch_enable_out ##1 flags_r.ovpl)
    else $error("switching while above overvoltage-low"); // R09
  init_target_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (state_r == ABS_ST_INIT) |=> target_r == `ABS_TGT_INIT)
    else $error("initial target not held"); // R05
  ext_spread_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    ext_clk |-> !spread_enable_out)
    else $error("spread on with external clock"); // R14
  ocp_flag_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (uvp_expire && state_r == ABS_ST_ADAPT) |=> flags_r.ocp)
    else $error("overcurrent flag missed"); // R11
  raise_step_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (state_r == ABS_ST_ADAPT && samp_r == `ABS_SAMPLE_CYC && any_low
     && target_r != `ABS_TGT_MAX && sinks_active_r && !over_high && !uvp_expire)
    |=> target_r == $past(target_r) + 10'h001)
    else $error("target not raised"); // R03
  spread_rst_a: assert property (@(posedge clk_sys_in)
    $past(reset_in) |-> spread_r == {`ABS_SPR_DEV_RST, `ABS_SPR_RATE_RST})
    else $error("spread reset values wrong"); // R16 R17
  static_lvl_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !ext_clk |-> spread_enable_out == sync_level)
    else $error("spread not following sync level"); // R13 R15
  sync_edge_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    ($changed(boost_sync_input_in) && !$past(reset_in)) |=> ext_clk)
    else $error("sync toggle not seen as external clock"); // R18
endmodule
`default_nettype wire

// file: tb/abs_boost_model.sv
`timescale 1ns/10ps
`default_nettype none
// stand-in for the analog boost stage and the sync source
module abs_boost_model (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [9:0] target_in,
  input wire logic [9:0] offset_in,
  input wire logic [1:0] sync_mode_in,
  output logic [9:0] level_out,
  output logic sync_out
);
  logic [2:0] div_r;
  logic tog_r;
  // output voltage follows the target with a chosen error, wraps like the code
  assign level_out = target_in + offset_in;
  // sync clock of 12 system cycles (about 2.08 MHz), inside the legal band
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      div_r <= 3'h0;
      tog_r <= 1'b0;
    end else begin
      div_r <= (div_r == 3'h5) ? 3'h0 : div_r + 3'h1;
      if (div_r == 3'h5) begin
        tog_r <= ~tog_r;
      end
    end
  end
  // mode 0 static low, 1 static high, 2 running clock
  assign sync_out = (sync_mode_in == 2'h2) ? tog_r : sync_mode_in[0];
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "abs_defs.svh"
module tb;
  import abs_pkg::*;
  typedef struct packed {
    logic [5:0] cfg;
    logic opn;
    logic act;
    logic [47:0] snk;
    logic [5:0] flt;
    logic [1:0] dir;
    logic [1:0] dev;
    logic [1:0] rate;
  } abs_row_t;
  // dir: 0 target holds at its initial point, 1 must rise, 2 must fall
  localparam abs_row_t ROWS [8] = '{
    '{6'h3F, 1'b0, 1'b0, {6{8'h10}}, 6'h00, 2'h0, 2'h0, 2'h0},
    '{6'h3F, 1'b0, 1'b1, {6{8'h10}}, 6'h00, 2'h1, 2'h1, 2'h1},
    '{6'h3F, 1'b0, 1'b1, {6{8'h30}}, 6'h00, 2'h2, 2'h2, 2'h2},
    '{6'h01, 1'b0, 1'b1, {{5{8'h10}}, 8'h30}, 6'h00, 2'h2, 2'h3, 2'h3},
    '{6'h03, 1'b0, 1'b1, {{5{8'h10}}, 8'h30}, 6'h02, 2'h2, 2'h0, 2'h3},
    '{6'h3F, 1'b1, 1'b1, {6{8'h30}}, 6'h00, 2'h1, 2'h2, 2'h1},
    '{6'h00, 1'b0, 1'b1, {6{8'h30}}, 6'h00, 2'h1, 2'h1, 2'h0},
    '{6'h3F, 1'b0, 1'b1, {6{8'h24}}, 6'h00, 2'h0, 2'h3, 2'h2}
  };
  logic clk = 1'b0, rst = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [47:0] snk = 48'h0;
  logic [5:0] flt = 6'h00;
  logic [9:0] lvl, tgt, off = 10'h000;
  logic [1:0] smode = 2'h0, sdev, srate, r;
  logic sync, sw, rec, ext, sen;
  int bad_count = 0, tests_run = 0, cyc = 0;
  // clock at 25 MHz
  always #20 clk = ~clk;
  abs_top #(.UVP_CYC(50)) abs_top_inst (.clk_sys_in(clk), .reset_in(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sink_output_pin_in(snk),
    .string_fault_in(flt), .boost_level_in(lvl), .boost_sync_input_in(sync),
    .boost_target_out(tgt), .switch_enable_out(sw), .fault_recovery_out(rec),
    .ext_sync_select_out(ext), .spread_enable_out(sen),
    .spread_deviation_out(sdev), .spread_modulation_rate_out(srate));
  abs_boost_model abs_boost_model_inst (.clk_sys_in(clk), .reset_in(rst),
    .target_in(tgt), .offset_in(off), .sync_mode_in(smode), .level_out(lvl),
    .sync_out(sync));
  task automatic final_report();
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chkv(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask
  // address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] er);
    logic ad, wd, ha, hw;
    logic [1:0] br;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // ready is looked at once settled, then acted on at the edge that takes it
    while (!(ad && wd)) begin
      @(negedge clk);
      ha = awvalid && (awready === 1'b1);
      hw = wvalid && (wready === 1'b1);
      @(posedge clk);
      if (ha) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (hw) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    br = bresp;
    @(posedge clk);
    bready <= 1'b0;
    chkv("bresp", {30'h0, er}, {30'h0, br});
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic rdx(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a, d, r);
    chkv("rdata", e, d);
    chkv("rresp", {30'h0, er}, {30'h0, r});
  endtask
  initial begin
    // adaptive loop and spread settings, one row at a time
    foreach (ROWS[i]) begin
      do_reset();
      snk <= ROWS[i].snk;
      flt <= ROWS[i].flt;
      wr(`ABS_OFS_CTRL, {22'h0, ROWS[i].cfg, 2'b00, ROWS[i].opn, ROWS[i].act}, 4'h3,
         2'b00);
      wr(`ABS_OFS_SPREAD, {26'h0, ROWS[i].rate, 2'b00, ROWS[i].dev}, 4'h1, 2'b00);
      repeat (600) @(posedge clk);
      chkv("dev", {30'h0, ROWS[i].dev}, {30'h0, sdev});
      chkv("rate", {30'h0, ROWS[i].rate}, {30'h0, srate});
      if (ROWS[i].dir == 2'h0) begin
        chkv("target hold", 32'h0000_0384, {22'h0, tgt});
      end else begin
        chk1("target dir", 1'b1, (ROWS[i].dir == 2'h1) ? (tgt > `ABS_TGT_INIT)
             : (tgt < `ABS_TGT_INIT));
      end
    end
    // reset values and unmapped space
    do_reset();
    rdx(`ABS_OFS_CTRL, 32'h0000_03F0, 2'b00);
    rdx(`ABS_OFS_STATUS, 32'h0000_0000, 2'b00);
    rdx(`ABS_OFS_TARGET, 32'h0000_0384, 2'b00);
    rdx(`ABS_OFS_SPREAD, 32'h0000_0002, 2'b00);
    rdx(`ABS_OFS_HEAD, 32'h0000_0020, 2'b00);
    rdx(12'h014, 32'h0000_0000, 2'b10);
    wr(12'h014, 32'h0000_0000, 4'hF, 2'b10);
    rdx(`ABS_OFS_CTRL, 32'h0000_03F0, 2'b00);
    chk1("spread low", 1'b0, sen);
    // external clock, then stop high, then low
    smode <= 2'h2;
    repeat (60) @(posedge clk);
    chk1("ext on", 1'b1, ext);
    chk1("spread ext", 1'b0, sen);
    smode <= 2'h1;
    repeat (560) @(posedge clk);
    chk1("ext off", 1'b0, ext);
    chk1("spread high", 1'b1, sen);
    smode <= 2'h0;
    repeat (560) @(posedge clk);
    chk1("spread off", 1'b0, sen);
    // overvoltage-low, boundary one code under first
    snk <= {6{8'h24}};
    wr(`ABS_OFS_CTRL, 32'h0000_03F1, 4'h3, 2'b00);
    off <= 10'h02B;
    repeat (4) @(posedge clk);
    chk1("below ovpl", 1'b1, sw);
    off <= 10'h02C;
    repeat (4) @(posedge clk);
    chk1("ovpl stop", 1'b0, sw);
    chk1("ovpl no recov", 1'b0, rec);
    rd(`ABS_OFS_STATUS, d, r);
    chk1("ovpl flag", 1'b1, d[0]);
    off <= 10'h000;
    repeat (4) @(posedge clk);
    chk1("ovpl resume", 1'b1, sw);
    wr(`ABS_OFS_STATUS, 32'h0000_0007, 4'h1, 2'b00);
    // overvoltage-high
    off <= 10'h072;
    repeat (4) @(posedge clk);
    chk1("ovph recov", 1'b1, rec);
    rd(`ABS_OFS_STATUS, d, r);
    chk1("ovph flag", 1'b1, d[1]);
    off <= 10'h000;
    wr(`ABS_OFS_CTRL, 32'h0000_03F0, 4'h3, 2'b00);
    wr(`ABS_OFS_STATUS, 32'h0000_0007, 4'h1, 2'b00);
    wr(`ABS_OFS_CTRL, 32'h0000_03F1, 4'h3, 2'b00);
    // short undervoltage dip, then one longer than the timer
    off <= 10'h3BD;
    repeat (30) @(posedge clk);
    off <= 10'h000;
    repeat (60) @(posedge clk);
    chk1("uvp short", 1'b0, rec);
    rd(`ABS_OFS_STATUS, d, r);
    chk1("uvp no ocp", 1'b0, d[2]);
    off <= 10'h3BD;
    repeat (70) @(posedge clk);
    chk1("uvp recov", 1'b1, rec);
    rd(`ABS_OFS_STATUS, d, r);
    chk1("ocp flag", 1'b1, d[2]);
    chk1("recov bit", 1'b1, d[5]);
    // headroom setting is writable and reads back
    wr(`ABS_OFS_HEAD, 32'h0000_0030, 4'h1, 2'b00);
    rdx(`ABS_OFS_HEAD, 32'h0000_0030, 2'b00);
    final_report();
  end
endmodule
`default_nettype wire
